// *** include/plrp_params.svh ***
`ifndef PLRP_PARAMS_SVH
`define PLRP_PARAMS_SVH

`define PLRP_ADDR_STATUS   16'h0011
`define PLRP_ADDR_IRQSTAT  16'h0012
`define PLRP_ADDR_IRQMASK  16'h0013
`define PLRP_ADDR_PINCFG   16'h0019
`define PLRP_ADDR_REGCTL   16'h00D0

`define PLRP_CFG_LEDMODE2  0
`define PLRP_CFG_PINIRQ    1
`define PLRP_REGCTL_OFF    15

`define PLRP_IRQ_LINK      0
`define PLRP_IRQ_EVENT     1
`define PLRP_IRQ_SLEEP     2
`define PLRP_IRQ_BITS      3

`define PLRP_RST_CFG       2'h0
`define PLRP_RST_REGCTL    16'h0000
`define PLRP_RST_IRQ       3'h0

`define PLRP_CLK_PERIOD_PS 8000
`define PLRP_RESET_MIN_NS  1000
`define PLRP_RESET_CYC \
	((`PLRP_RESET_MIN_NS * 1000 + `PLRP_CLK_PERIOD_PS - 1) / `PLRP_CLK_PERIOD_PS)
`define PLRP_BLINK_HALF_MS 50
`define PLRP_BLINK_CYC \
	((64'd`PLRP_BLINK_HALF_MS * 64'd1000000000) / 64'd`PLRP_CLK_PERIOD_PS)

`endif

// *** include/plrp_pkg.sv ***
package plrp_pkg;
	typedef enum logic [1:0] {ST_INIT, ST_LATCH, ST_RUN} plrp_state_t;
	typedef logic [15:0] plrp_word_t;
endpackage : plrp_pkg

// *** include/plrp_led_if.sv ***
`timescale 1ns/1ps
interface plrp_led_if;
	logic activity;
	logic blinkActive;
	logic blinkPhase;
	modport core  (output activity, input blinkActive, input blinkPhase);
	modport blink (input activity, output blinkActive, output blinkPhase);
endinterface : plrp_led_if

// *** logic/plrp_blink.sv ***
`timescale 1ns/1ps
`include "plrp_params.svh"
module plrp_blink
	import plrp_pkg::*;
#(
	parameter int unsigned BLINK_CYCLES = int'(`PLRP_BLINK_CYC)
) (
	// Clock and reset
	input wire logic    clock,
	input wire logic    rstSyncB,
	// Blink control
	plrp_led_if.blink   led
);
	logic [31:0] halfCount;
	logic        tick;
	logic        actSeen;

	assign tick = (halfCount == 32'(BLINK_CYCLES - 1));

	always_ff @(posedge clock or negedge rstSyncB) begin
		if (!rstSyncB)
			halfCount <= 32'h00000000;
		else if (tick)
			halfCount <= 32'h00000000;
		else
			halfCount <= halfCount + 32'h00000001;
	end

	// Activity is remembered over a whole half period, so a single short frame still shows.
	always_ff @(posedge clock or negedge rstSyncB) begin
		if (!rstSyncB)
			actSeen <= 1'b0;
		else if (tick)
			actSeen <= led.activity;
		else if (led.activity)
			actSeen <= 1'b1;
	end

	always_ff @(posedge clock or negedge rstSyncB) begin
		if (!rstSyncB) begin
			led.blinkActive <= 1'b0;
			led.blinkPhase  <= 1'b0;
		end else if (tick) begin
			led.blinkActive <= actSeen;
			led.blinkPhase  <= actSeen ? ~led.blinkPhase : 1'b0;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstSyncB);

	a_blink_toggles: assert property (tick && actSeen |=> led.blinkPhase != $past(led.blinkPhase))
		else $error("blink phase did not toggle at half-period tick");
	a_blink_stops: assert property (tick && !actSeen |=> !led.blinkActive && !led.blinkPhase)
		else $error("blink continued without activity");
	c_blink_run: cover property (led.blinkActive && tick);
endmodule : plrp_blink

// *** logic/plrp_top.sv ***
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "plrp_params.svh"
module plrp_top
	import plrp_pkg::*;
#(
	parameter int unsigned BLINK_CYCLES = int'(`PLRP_BLINK_CYC)
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_b,
	// Register port
	input  wire logic [15:0] regAddr,
	input  wire logic [15:0] regWrData,
	input  wire logic        regWrEn,
	input  wire logic        regRdEn,
	output      logic [15:0] regRdData,
	// Transceiver core state
	input  wire logic        linkGood,
	input  wire logic        txActive,
	input  wire logic        rxActive,
	input  wire logic        intEvent,
	// Straps
	input  wire logic        ledModeStrap,
	// Link status LED pin, also the duplex strap
	input  wire logic        linkStatusLedIn,
	output      logic        linkStatusLedOut,
	output      logic        linkStatusLedOeB,
	// Shared interrupt or sleep pin
	input  wire logic        irqOrSleepPinIn,
	output      logic        irqOrSleepPinOut,
	output      logic        irqOrSleepPinOeB,
	// Status
	output      logic        powerDown,
	output      logic        regulatorOff,
	output      logic        autonegDuplexStrap,
	output      logic        coreReady,
	output      logic        irq
);
	localparam int RST_CYC = `PLRP_RESET_CYC;

	function automatic logic hit(input plrp_word_t addr, input plrp_word_t off);
		hit = (addr == off);
	endfunction : hit

	plrp_led_if  led ();

	logic                       rstMeta;
	logic                       rstSyncB;
	logic                       sleepMeta;
	logic                       sleepSync;
	plrp_state_t                state_reg;
	plrp_state_t                state_next;
	logic [7:0]                 initCount;
	logic                       ledMode2_reg;
	logic                       pinIrq_reg;
	plrp_word_t                 regCtl_reg;
	logic [`PLRP_IRQ_BITS-1:0]  irqStat_reg;
	logic [`PLRP_IRQ_BITS-1:0]  irqMask_reg;
	logic [`PLRP_IRQ_BITS-1:0]  irqEvents;
	logic [`PLRP_IRQ_BITS-1:0]  irqClear;
	logic                       linkPrev;
	logic                       ledOn_next;
	logic                       running;
	logic                       wrCfg;
	plrp_word_t                 rdValue;

	// Reset asserts at once but releases on the clock, so no flop sees a runt release.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta  <= 1'b0;
			rstSyncB <= 1'b0;
		end else begin
			rstMeta  <= 1'b1;
			rstSyncB <= rstMeta;
		end
	end

	always_ff @(posedge clock or negedge rstSyncB) begin
		if (!rstSyncB) begin
			sleepMeta <= 1'b1;
			sleepSync <= 1'b1;
		end else begin
			sleepMeta <= irqOrSleepPinIn;
			sleepSync <= sleepMeta;
		end
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_INIT:  state_next = (initCount == 8'(RST_CYC - 1)) ? ST_LATCH : ST_INIT;
			ST_LATCH: state_next = ST_RUN;
			ST_RUN:   state_next = ST_RUN;
			default:  state_next = ST_INIT;
		endcase
	end

	// Internal reset is stretched by a full minimum reset time before straps are taken.
	always_ff @(posedge clock or negedge rstSyncB) begin
		if (!rstSyncB)
			state_reg <= ST_INIT;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge clock or negedge rstSyncB) begin
		if (!rstSyncB)
			initCount <= 8'h00;
		else if (state_reg == ST_INIT)
			initCount <= initCount + 8'h01;
	end

	assign running   = (state_reg == ST_RUN);
	assign coreReady = running;
	assign wrCfg     = regWrEn && hit(regAddr, `PLRP_ADDR_PINCFG);

	// Straps are caught by a clocked process after release, never by the reset itself.
	always_ff @(posedge clock or negedge rstSyncB) begin
		if (!rstSyncB) begin
			ledMode2_reg <= 1'((`PLRP_RST_CFG >> `PLRP_CFG_LEDMODE2) & 2'h1);
			pinIrq_reg   <= 1'b0;
		end else if (state_reg == ST_LATCH) begin
			ledMode2_reg <= ~ledModeStrap;
			pinIrq_reg   <= 1'b0;
		end else if (wrCfg) begin
			ledMode2_reg <= regWrData[`PLRP_CFG_LEDMODE2];
			pinIrq_reg   <= regWrData[`PLRP_CFG_PINIRQ];
		end
	end

	always_ff @(posedge clock or negedge rstSyncB) begin
		if (!rstSyncB)
			autonegDuplexStrap <= 1'b1;
		else if (state_reg == ST_LATCH)
			autonegDuplexStrap <= linkStatusLedIn;
	end

	always_ff @(posedge clock or negedge rstSyncB) begin
		if (!rstSyncB)
			regCtl_reg <= `PLRP_RST_REGCTL;
		else if (regWrEn && hit(regAddr, `PLRP_ADDR_REGCTL))
			regCtl_reg <= regWrData;
	end

	assign regulatorOff = regCtl_reg[`PLRP_REGCTL_OFF];

	always_ff @(posedge clock or negedge rstSyncB) begin
		if (!rstSyncB)
			linkPrev <= 1'b0;
		else
			linkPrev <= linkGood;
	end

	assign irqEvents = {
		(!pinIrq_reg && !sleepSync && !powerDown),
		intEvent,
		(running && (linkGood != linkPrev))
	};
	assign irqClear = (regWrEn && hit(regAddr, `PLRP_ADDR_IRQSTAT)) ?
		regWrData[`PLRP_IRQ_BITS-1:0] : `PLRP_RST_IRQ;

	// A new event wins over a clear in the same cycle.
	always_ff @(posedge clock or negedge rstSyncB) begin
		if (!rstSyncB)
			irqStat_reg <= `PLRP_RST_IRQ;
		else
			irqStat_reg <= (irqStat_reg & ~irqClear) | irqEvents;
	end

	always_ff @(posedge clock or negedge rstSyncB) begin
		if (!rstSyncB)
			irqMask_reg <= `PLRP_RST_IRQ;
		else if (regWrEn && hit(regAddr, `PLRP_ADDR_IRQMASK))
			irqMask_reg <= regWrData[`PLRP_IRQ_BITS-1:0];
	end

	assign irq = |(irqStat_reg & irqMask_reg);

	always_ff @(posedge clock or negedge rstSyncB) begin
		if (!rstSyncB)
			powerDown <= 1'b0;
		else
			powerDown <= running && !pinIrq_reg && !sleepSync;
	end

	// The pin only ever sinks; the weak pull-up gives the high level.
	assign irqOrSleepPinOut = 1'b0;
	always_ff @(posedge clock or negedge rstSyncB) begin
		if (!rstSyncB)
			irqOrSleepPinOeB <= 1'b1;
		else
			irqOrSleepPinOeB <= !(running && pinIrq_reg && irq);
	end

	assign led.activity = txActive || rxActive;

	plrp_blink #(
		.BLINK_CYCLES (BLINK_CYCLES)
	) u_blink (
		.clock    (clock),
		.rstSyncB (rstSyncB),
		.led      (led)
	);

	always_comb begin
		if (!ledMode2_reg)
			ledOn_next = linkGood;
		else if (led.blinkActive)
			ledOn_next = led.blinkPhase;
		else
			ledOn_next = linkGood;
	end

	// The LED pin stays released until straps are taken, as it doubles as a strap.
	always_ff @(posedge clock or negedge rstSyncB) begin
		if (!rstSyncB) begin
			linkStatusLedOut <= 1'b0;
			linkStatusLedOeB <= 1'b1;
		end else begin
			linkStatusLedOut <= running && ledOn_next;
			linkStatusLedOeB <= !running;
		end
	end

	always_comb begin
		rdValue = 16'h0000;
		if (hit(regAddr, `PLRP_ADDR_STATUS))
			rdValue = {10'h000, autonegDuplexStrap, ledMode2_reg, regulatorOff,
				powerDown, led.activity, linkGood};
		else if (hit(regAddr, `PLRP_ADDR_IRQSTAT))
			rdValue = {13'h0000, irqStat_reg};
		else if (hit(regAddr, `PLRP_ADDR_IRQMASK))
			rdValue = {13'h0000, irqMask_reg};
		else if (hit(regAddr, `PLRP_ADDR_PINCFG))
			rdValue = {14'h0000, pinIrq_reg, ledMode2_reg};
		else if (hit(regAddr, `PLRP_ADDR_REGCTL))
			rdValue = regCtl_reg;
	end

	always_ff @(posedge clock or negedge rstSyncB) begin
		if (!rstSyncB)
			regRdData <= 16'h0000;
		else
			regRdData <= regRdEn ? rdValue : 16'h0000;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstSyncB);

	a_led_mode_one: assert property (running && !ledMode2_reg |=>
		linkStatusLedOut == $past(linkGood))
		else $error("mode one LED does not follow link");
	a_led_mode_two: assert property (running && ledMode2_reg && linkGood
		&& !led.blinkActive |=> linkStatusLedOut)
		else $error("mode two LED dark with good link");
	a_led_blinks: assert property (running && ledMode2_reg && led.blinkActive |=>
		linkStatusLedOut == $past(led.blinkPhase))
		else $error("mode two LED not showing blink phase");
	a_reset_defaults: assert property ($rose(rstSyncB) |->
		regCtl_reg == `PLRP_RST_REGCTL && irqMask_reg == `PLRP_RST_IRQ && !powerDown)
		else $error("register not at default after reset");
	property p_reset_stretch;
		@(posedge clock) disable iff (!rst_b)
		$rose(rstSyncB) |-> ##RST_CYC (state_reg == ST_LATCH) ##1 running;
	endproperty
	a_reset_stretch: assert property (p_reset_stretch)
		else $error("reset process length wrong");
	a_strap_latch: assert property (state_reg == ST_LATCH |=>
		ledMode2_reg == !$past(ledModeStrap) && autonegDuplexStrap == $past(linkStatusLedIn))
		else $error("straps not relatched");
	a_pin_func_write: assert property ($changed(pinIrq_reg) |-> $past(wrCfg))
		else $error("pin function changed without a write");
	a_pin_default_sleep: assert property (state_reg == ST_LATCH |=> !pinIrq_reg)
		else $error("pin not power-down after reset");
	a_sleep_entry: assert property ($fell(irqOrSleepPinIn) ##1
		(!irqOrSleepPinIn && !pinIrq_reg && running) [*2] |=> powerDown)
		else $error("power-down not entered three cycles after pin low");
	a_irq_pulls_low: assert property (running && pinIrq_reg && irq |=> !irqOrSleepPinOeB)
		else $error("interrupt pin not pulled low");
	a_pin_release: assert property (!irqOrSleepPinOeB |-> $past(pinIrq_reg && irq))
		else $error("pin driven without interrupt function");
	a_mode_write: assert property (wrCfg && running |=>
		ledMode2_reg == $past(regWrData[`PLRP_CFG_LEDMODE2]))
		else $error("LED mode write lost");
	a_regulator_off: assert property (regWrEn && hit(regAddr, `PLRP_ADDR_REGCTL) |=>
		regulatorOff == $past(regWrData[`PLRP_REGCTL_OFF]))
		else $error("regulator control bit not applied");
	a_irq_set_wins: assert property (|(irqEvents & irqClear) |=> |(irqStat_reg & $past(irqEvents)))
		else $error("event lost against clear");

	c_mode_two_blink: cover property (running && ledMode2_reg && led.blinkActive);
	c_irq_pin_low: cover property (!irqOrSleepPinOeB);
	c_sleep: cover property ($rose(powerDown));
	c_regulator: cover property ($rose(regulatorOff));
endmodule : plrp_top

// *** test/plrp_far_side.sv ***
`timescale 1ns/1ps
// Board around the device: the LED with its strap resistor, and the host side of the
// shared pin. The shared pin carries a weak pull-up and reads high when released; a released LED pin shows its strap resistor.
module plrp_far_side (
	// LED pin
	input  wire logic linkStatusLedOut,
	input  wire logic linkStatusLedOeB,
	input  wire logic duplexPullDown,
	output      logic ledPinLevel,
	// Shared interrupt or sleep pin
	input  wire logic irqOrSleepPinOut,
	input  wire logic irqOrSleepPinOeB,
	input  wire logic hostPullLow,
	output      logic irqPinLevel
);
	// A released LED pin shows the strap resistor, which is all the device samples.
	assign ledPinLevel = !linkStatusLedOeB ? linkStatusLedOut : !duplexPullDown;
	// Open drain: either party may pull low; otherwise the pull-up wins.
	assign irqPinLevel = (!irqOrSleepPinOeB && !irqOrSleepPinOut) ? 1'b0 :
		(hostPullLow ? 1'b0 : 1'b1);
endmodule : plrp_far_side

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench
	import plrp_pkg::*;
;
	localparam int unsigned BLINK = 8;
	logic clock = 1'b0, rst_b = 1'b0;
	logic [15:0] regAddr = 16'h0000, regWrData = 16'h0000, regRdData;
	logic regWrEn = 1'b0, regRdEn = 1'b0;
	logic linkGood = 1'b0, txActive = 1'b0, rxActive = 1'b0, intEvent = 1'b0;
	logic ledModeStrap = 1'b1, duplexPullDown = 1'b0, hostPullLow = 1'b0;
	logic ledPin, ledOut, ledOeB, irqPin, pinOut, pinOeB;
	logic powerDown, regulatorOff, autonegDuplexStrap, coreReady, irq;
	int error_cnt = 0, num_checks = 0;

	always #4 clock = ~clock;

	plrp_top #(.BLINK_CYCLES(BLINK)) dut (.clock(clock), .rst_b(rst_b), .regAddr(regAddr),
		.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
		.linkGood(linkGood), .txActive(txActive), .rxActive(rxActive), .intEvent(intEvent),
		.ledModeStrap(ledModeStrap), .linkStatusLedIn(ledPin), .linkStatusLedOut(ledOut),
		.linkStatusLedOeB(ledOeB), .irqOrSleepPinIn(irqPin), .irqOrSleepPinOut(pinOut),
		.irqOrSleepPinOeB(pinOeB), .powerDown(powerDown), .regulatorOff(regulatorOff),
		.autonegDuplexStrap(autonegDuplexStrap), .coreReady(coreReady), .irq(irq));

	plrp_far_side far (.linkStatusLedOut(ledOut), .linkStatusLedOeB(ledOeB),
		.duplexPullDown(duplexPullDown), .ledPinLevel(ledPin), .irqOrSleepPinOut(pinOut),
		.irqOrSleepPinOeB(pinOeB), .hostPullLow(hostPullLow), .irqPinLevel(irqPin));

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("Checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic regWrite(input logic [15:0] a, input logic [15:0] d);
		@(posedge clock);
		regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clock);
		regWrEn <= 1'b0;
	endtask : regWrite

	task automatic regRead(input logic [15:0] a, output logic [15:0] d);
		@(posedge clock);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRdEn <= 1'b0;
		#1 d = regRdData;
	endtask : regRead

	task automatic readCheck(input string what, input logic [15:0] a, input logic [15:0] e);
		logic [15:0] d;
		regRead(a, d);
		check(what, d, e);
	endtask : readCheck

	// Holds reset for the given cycles, then waits a bounded time for the sequence.
	task automatic doReset(input int cycles);
		int n;
		n = 0;
		@(posedge clock);
		rst_b <= 1'b0;
		repeat (cycles) @(posedge clock);
		rst_b <= 1'b1;
		while (coreReady !== 1'b1 && n < 300) begin
			@(posedge clock);
			n++;
		end
		check("coreReady", {15'h0, coreReady}, 16'h0001);
	endtask : doReset

	task automatic testDefaults();
		readCheck("pinCfg", 16'h0019, 16'h0000);
		readCheck("regCtl", 16'h00D0, 16'h0000);
		readCheck("irqMask", 16'h0013, 16'h0000);
		check("powerDown", {15'h0, powerDown}, 16'h0000);
		regWrite(16'h0055, 16'hFFFF);
		readCheck("unmapped", 16'h0055, 16'h0000);
		readCheck("pinCfgKept", 16'h0019, 16'h0000);
	endtask : testDefaults

	task automatic testRegulator();
		check("regOffRst", {15'h0, regulatorOff}, 16'h0000);
		regWrite(16'h00D0, 16'h7FFF);
		#1 check("regOffLow", {15'h0, regulatorOff}, 16'h0000);
		regWrite(16'h00D0, 16'h8000);
		#1 check("regOff", {15'h0, regulatorOff}, 16'h0001);
		readCheck("regCtlRd", 16'h00D0, 16'h8000);
		@(posedge clock);
		#1 check("rdDataDrops", regRdData, 16'h0000);
		readCheck("statusRd", 16'h0011, 16'h0028);
	endtask : testRegulator

	task automatic testModeOne();
		@(posedge clock);
		linkGood <= 1'b1;
		#1 check("ledBefore", {15'h0, ledOut}, 16'h0000);
		@(posedge clock);
		#1 check("ledOn", {15'h0, ledOut}, 16'h0001);
		check("ledDriven", {15'h0, ledOeB}, 16'h0000);
		txActive <= 1'b1;
		repeat (3 * BLINK) @(posedge clock);
		#1 check("noBlinkMode1", {15'h0, ledOut}, 16'h0001);
		txActive <= 1'b0;
		linkGood <= 1'b0;
		@(posedge clock);
		#1 check("ledOff", {15'h0, ledOut}, 16'h0000);
		readCheck("linkChgStat", 16'h0012, 16'h0001);
	endtask : testModeOne

	task automatic testModeTwo();
		int toggles;
		logic prev;
		toggles = 0;
		regWrite(16'h0019, 16'h0001);
		linkGood <= 1'b1;
		repeat (3 * BLINK) @(posedge clock);
		#1 check("mode2Link", {15'h0, ledOut}, 16'h0001);
		rxActive <= 1'b1;
		prev = ledOut;
		repeat (6 * BLINK) begin
			@(posedge clock);
			#1 if (ledOut !== prev) toggles++;
			prev = ledOut;
		end
		check("blinkToggles", 16'(toggles >= 4 && toggles <= 5), 16'h0001);
		rxActive <= 1'b0;
		repeat (3 * BLINK + 2) @(posedge clock);
		#1 check("blinkStops", {15'h0, ledOut}, 16'h0001);
		linkGood <= 1'b0;
		@(posedge clock);
		#1 check("mode2Off", {15'h0, ledOut}, 16'h0000);
	endtask : testModeTwo

	task automatic testSleep();
		regWrite(16'h0012, 16'h0007);
		hostPullLow <= 1'b1;
		repeat (4) @(posedge clock);
		#1 check("sleepEnter", {15'h0, powerDown}, 16'h0001);
		check("sleepNoDrive", {15'h0, pinOeB}, 16'h0001);
		readCheck("sleepStat", 16'h0012, 16'h0004);
		hostPullLow <= 1'b0;
		repeat (4) @(posedge clock);
		#1 check("sleepLeave", {15'h0, powerDown}, 16'h0000);
	endtask : testSleep

	task automatic testIrqPin();
		regWrite(16'h0012, 16'h0007);
		regWrite(16'h0019, 16'h0002);
		@(posedge clock);
		intEvent <= 1'b1;
		@(posedge clock);
		intEvent <= 1'b0;
		repeat (2) @(posedge clock);
		#1 check("maskedIrq", {15'h0, irq}, 16'h0000);
		check("maskedPin", {15'h0, irqPin}, 16'h0001);
		readCheck("evtStat", 16'h0012, 16'h0002);
		regWrite(16'h0013, 16'h0002);
		repeat (2) @(posedge clock);
		#1 check("irqPinLow", {15'h0, irqPin}, 16'h0000);
		check("noSleepOnIrq", {15'h0, powerDown}, 16'h0000);
		regWrite(16'h0012, 16'h0002);
		repeat (2) @(posedge clock);
		#1 check("irqReleased", {15'h0, irqPin}, 16'h0001);
		check("irqOut", {15'h0, irq}, 16'h0000);
		// An event in the very cycle of its clear must survive the clear.
		intEvent <= 1'b1;
		regWrite(16'h0012, 16'h0002);
		intEvent <= 1'b0;
		readCheck("setWins", 16'h0012, 16'h0002);
	endtask : testIrqPin

	task automatic testReReset();
		ledModeStrap <= 1'b0;
		duplexPullDown <= 1'b1;
		doReset(125);
		check("duplexStrap", {15'h0, autonegDuplexStrap}, 16'h0000);
		readCheck("strapMode2", 16'h0019, 16'h0001);
		readCheck("regCtlCleared", 16'h00D0, 16'h0000);
		readCheck("maskCleared", 16'h0013, 16'h0000);
		check("regOffCleared", {15'h0, regulatorOff}, 16'h0000);
	endtask : testReReset

	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		tally_and_finish();
	end

	initial begin
		doReset(2);
		check("duplexDefault", {15'h0, autonegDuplexStrap}, 16'h0001);
		testDefaults();
		testRegulator();
		testModeOne();
		testModeTwo();
		testSleep();
		testIrqPin();
		testReReset();
		tally_and_finish();
	end
endmodule : testbench
